// ==== tte_engine.sv ====
/*
 * Event triggered transfer engine and its 4-word data FIFO.
 * Assumes a memory port that answers each held request with one ack
 * pulse, and a request line from logic on the same clock.
 */
// Contract
// RULE_01 - A rising channel 0 request starts one transfer activation.
// RULE_02 - Descriptor sits at base: mode A, source, mode B, dest, counts.
// RULE_03 - Source mode bits: 0x fixed, 10 increment, 11 decrement.
// RULE_04 - Address step is one for byte units and two for word units.
// RULE_05 - Destination mode bits: 0x fixed, 10 increment, 11 decrement.
// RULE_06 - Mode field: 00 normal, 01 repeat, 10 block; 11 is forbidden.
// RULE_07 - Area select 0 makes destination the area, 1 the source.
// RULE_08 - Size bit of mode A selects byte or word units.
// RULE_09 - Software uses normal mode for the I2C transmit case.
// RULE_10 - Chain bit 0 ends after this descriptor, 1 fetches the next.
// RULE_11 - Select bit 0 interrupts CPU only at count zero; 1 every time.
// RULE_12 - Count A counts transfers, count B counts blocks in block mode.
// RULE_13 - Normal mode moves one unit, steps, decrements, ends at zero.
`timescale 1ns/10ps
`default_nettype none

module tte_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_b_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} tte_fifo_st_t;
	tte_fifo_st_t s;
	tte_fifo_st_t next_s;
	logic         push;
	logic         pop;

	assign in_ready_out  = (s.cnt != (AW+1)'(DEPTH));
	assign out_valid_out = (s.cnt != '0);
	assign out_data_out  = s.mem[s.rp];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_ready_in & out_valid_out;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data_in;
			next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : tte_fifo

module tte_engine
	import tte_pkg::*;
#(
	parameter logic [23:0] BASE_ADDR  = DESC_BASE,
	parameter int          FIFO_DEPTH = 4
) (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_b_in,
	input  wire logic              i2c_channel0_request_in,
	output tte_mem_req_t           mem_out,
	input  wire logic              mem_ack_in,
	input  wire logic [15:0]       mem_rdata_in,
	output logic                   cpu_irq_out,
	output logic                   busy_out,
	output logic [7:0]             transfer_mode_a_out
);
	typedef struct packed {
		tte_state_t                 st;
		logic                       prev;
		logic                       pend;
		logic [DESC_BYTES-1:0][7:0] desc;
		logic [3:0]                 idx;
		logic [23:0]                dptr;
		logic [23:0]                src;
		logic [23:0]                dst;
		logic [23:0]                area_base;
		logic [8:0]                 rd_left;
		logic [8:0]                 wr_left;
		logic                       irq_due;
		tte_mem_req_t               mem;
		logic                       irq;
		logic                       busy;
	} tte_st_t;

	tte_st_t       s;
	tte_st_t       next_s;
	logic          f_in_valid;
	logic          f_in_ready;
	logic          f_out_valid;
	logic          f_out_ready;
	logic [15:0]   f_out_data;

	function automatic logic [23:0] step_of(input logic [1:0] m,
			input logic sz);
		logic [23:0] d;
		d = sz ? 24'h000002 : 24'h000001; // see RULE_04
		if (!m[1]) begin
			step_of = 24'h000000;
		end else if (m[0]) begin
			step_of = 24'h000000 - d;
		end else begin
			step_of = d;
		end
	endfunction : step_of

	function automatic logic [7:0] desc_byte(input tte_st_t x,
			input logic [3:0] i);
		desc_byte = x.desc[DESC_BYTES-1-int'(i)];
	endfunction : desc_byte

	tte_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (f_in_valid),
		.in_ready_out  (f_in_ready),
		.in_data_in    (mem_rdata_in),
		.out_valid_out (f_out_valid),
		.out_ready_in  (f_out_ready),
		.out_data_out  (f_out_data)
	);

	always_comb begin
		logic [7:0]  transfer_mode_a;
		logic [7:0]  transfer_mode_b;
		logic [1:0]  mode;
		logic        sz;
		logic        area_src;
		logic [23:0] sstep;
		logic [23:0] dstep;
		logic [15:0] transfer_count_a;
		logic [15:0] block_count_b;
		logic [7:0]  cnt;
		logic        ended;
		logic        ack;
		next_s = s;
		transfer_mode_a = desc_byte(s, 4'(OFS_MODE_A));
		transfer_mode_b = desc_byte(s, 4'(OFS_MODE_B));
		mode = transfer_mode_a[XFER_MODE_HI:XFER_MODE_LO]; // see RULE_06
		sz = transfer_mode_a[UNIT_SIZE_BIT]; // see RULE_08
		area_src = transfer_mode_a[AREA_SIDE_BIT]; // see RULE_07
		sstep = step_of(transfer_mode_a[SRC_MODE_HI:SRC_MODE_LO], sz); // see RULE_03
		dstep = step_of(transfer_mode_a[DST_MODE_HI:DST_MODE_LO], sz); // see RULE_05
		transfer_count_a = {desc_byte(s, 4'(OFS_CNT_A)), desc_byte(s, 4'(OFS_CNT_A+1))};
		block_count_b = {desc_byte(s, 4'(OFS_CNT_B)), desc_byte(s, 4'(OFS_CNT_B+1))};
		cnt = 8'h00;
		ended = 1'b0;
		ack = s.mem.req & mem_ack_in;
		f_in_valid = 1'b0;
		f_out_ready = 1'b0;
		next_s.irq = 1'b0;
		next_s.prev = i2c_channel0_request_in;
		if (ack) begin
			next_s.mem.req = 1'b0;
		end
		unique case (s.st)
			TTE_IDLE: begin
				if (s.pend) begin
					next_s.pend = 1'b0;
					next_s.dptr = BASE_ADDR;
					next_s.idx = 4'h0;
					next_s.irq_due = 1'b0;
					next_s.st = TTE_FETCH; // see RULE_01
				end
			end
			TTE_FETCH: begin
				if (!s.mem.req) begin
					next_s.mem = '{1'b1, 1'b0, 1'b0,
						s.dptr + 24'(s.idx), 16'h0000}; // see RULE_02
				end else if (ack) begin
					next_s.desc[DESC_BYTES-1-int'(s.idx)] = mem_rdata_in[7:0];
					if (s.idx == LAST_IDX) begin
						next_s.st = TTE_SETUP;
					end else begin
						next_s.idx = s.idx + 4'h1;
					end
				end
			end
			TTE_SETUP: begin
				next_s.src = {desc_byte(s, 4'(OFS_SRC)),
					desc_byte(s, 4'(OFS_SRC+1)), desc_byte(s, 4'(OFS_SRC+2))};
				next_s.dst = {desc_byte(s, 4'(OFS_DST)),
					desc_byte(s, 4'(OFS_DST+1)), desc_byte(s, 4'(OFS_DST+2))};
				next_s.area_base = area_src ? next_s.src : next_s.dst;
				if (mode == MODE_BLOCK) begin
					next_s.rd_left = (transfer_count_a[15:8] == 8'h00) ? FULL_BLOCK
						: {1'b0, transfer_count_a[15:8]};
				end else begin
					next_s.rd_left = 9'h001; // see RULE_13
				end
				next_s.wr_left = next_s.rd_left;
				next_s.st = TTE_XFER;
			end
			TTE_XFER: begin
				if (s.mem.req) begin
					if (ack && !s.mem.we) begin
						f_in_valid = 1'b1;
						next_s.src = s.src + sstep; // see RULE_03
						next_s.rd_left = s.rd_left - 9'h001;
					end else if (ack) begin
						next_s.dst = s.dst + dstep; // see RULE_05
						next_s.wr_left = s.wr_left - 9'h001;
					end
				end else if (s.rd_left != 9'h000 && f_in_ready) begin
					next_s.mem = '{1'b1, 1'b0, sz, s.src, 16'h0000};
				end else if (f_out_valid) begin
					f_out_ready = 1'b1;
					next_s.mem = '{1'b1, 1'b1, sz, s.dst, f_out_data};
				end else if (s.wr_left == 9'h000) begin
					next_s.st = TTE_FIN;
				end
			end
			TTE_FIN: begin
				if (mode == MODE_REPEAT) begin
					cnt = transfer_count_a[7:0] - 8'h01;
					if (cnt == 8'h00) begin
						cnt = transfer_count_a[15:8];
						if (area_src) begin
							next_s.src = 24'(s.src - 24'(transfer_count_a[15:8]) * sstep);
						end else begin
							next_s.dst = 24'(s.dst - 24'(transfer_count_a[15:8]) * dstep);
						end
					end
					next_s.desc[DESC_BYTES-1-(OFS_CNT_A+1)] = cnt;
				end else if (mode == MODE_BLOCK) begin
					if (area_src) begin
						next_s.src = s.area_base; // see RULE_07
					end else begin
						next_s.dst = s.area_base;
					end
					block_count_b = block_count_b - 16'h0001; // see RULE_12
					ended = (block_count_b == 16'h0000);
					next_s.desc[DESC_BYTES-1-OFS_CNT_B] = block_count_b[15:8];
					next_s.desc[DESC_BYTES-1-(OFS_CNT_B+1)] = block_count_b[7:0];
				end else begin
					transfer_count_a = transfer_count_a - 16'h0001; // see RULE_13
					ended = (transfer_count_a == 16'h0000); // see RULE_12
					next_s.desc[DESC_BYTES-1-OFS_CNT_A] = transfer_count_a[15:8];
					next_s.desc[DESC_BYTES-1-(OFS_CNT_A+1)] = transfer_count_a[7:0];
				end
				next_s.irq_due = s.irq_due | ended
					| transfer_mode_b[CPU_IRQ_SEL_BIT]; // see RULE_11
				for (int b = 0; b < 3; b++) begin
					next_s.desc[DESC_BYTES-1-OFS_SRC-b] = next_s.src[23-8*b -: 8];
					next_s.desc[DESC_BYTES-1-OFS_DST-b] = next_s.dst[23-8*b -: 8];
				end
				next_s.idx = 4'h0;
				next_s.st = TTE_WB;
			end
			TTE_WB: begin
				if (!s.mem.req) begin
					next_s.mem = '{1'b1, 1'b1, 1'b0, s.dptr + 24'(s.idx),
						{8'h00, desc_byte(s, s.idx)}};
				end else if (ack) begin
					if (s.idx != LAST_IDX) begin
						next_s.idx = s.idx + 4'h1;
					end else if (transfer_mode_b[CHAIN_BIT]) begin
						next_s.dptr = s.dptr + DESC_STRIDE; // see RULE_10
						next_s.idx = 4'h0;
						next_s.st = TTE_FETCH;
					end else begin
						next_s.irq = s.irq_due; // see RULE_11
						next_s.st = TTE_IDLE; // see RULE_10
					end
				end
			end
		endcase
		if (i2c_channel0_request_in && !s.prev) begin
			next_s.pend = 1'b1; // see RULE_01
		end
		// Busy is registered so the output comes straight from a flip-flop.
		next_s.busy = (next_s.st != TTE_IDLE);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign mem_out             = s.mem;
	assign cpu_irq_out         = s.irq;
	assign busy_out            = s.busy;
	assign transfer_mode_a_out = s.desc[DESC_BYTES-1-OFS_MODE_A];
endmodule : tte_engine
`default_nettype wire

// ==== tte_pkg.sv ====
/*
 * Constants and types shared by the event triggered transfer engine.
 * Assumes byte addressed memory with a 24-bit address space.
 */
`default_nettype none
package tte_pkg;
	localparam int          ADDR_W      = 24;
	localparam int          DATA_W      = 16;
	localparam int          DESC_BYTES  = 12;
	localparam logic [23:0] DESC_BASE   = 24'hEC00;
	localparam logic [23:0] DESC_STRIDE = 24'h00000C;
	// Byte offsets of the descriptor fields, most significant byte first.
	localparam int          OFS_MODE_A  = 0;
	localparam int          OFS_SRC     = 1;
	localparam int          OFS_MODE_B  = 4;
	localparam int          OFS_DST     = 5;
	localparam int          OFS_CNT_A   = 8;
	localparam int          OFS_CNT_B   = 10;
	localparam logic [3:0]  LAST_IDX    = 4'hB;
	// Field positions inside the two mode bytes.
	localparam int          SRC_MODE_HI = 7;
	localparam int          SRC_MODE_LO = 6;
	localparam int          DST_MODE_HI = 5;
	localparam int          DST_MODE_LO = 4;
	localparam int          XFER_MODE_HI = 3;
	localparam int          XFER_MODE_LO = 2;
	localparam int          AREA_SIDE_BIT = 1;
	localparam int          UNIT_SIZE_BIT = 0;
	localparam int          CHAIN_BIT   = 7;
	localparam int          CPU_IRQ_SEL_BIT = 6;
	localparam logic [1:0]  MODE_NORMAL = 2'h0;
	localparam logic [1:0]  MODE_REPEAT = 2'h1;
	localparam logic [1:0]  MODE_BLOCK  = 2'h2;
	localparam logic [8:0]  FULL_BLOCK  = 9'h100;

	typedef enum logic [2:0] {
		TTE_IDLE, TTE_FETCH, TTE_SETUP, TTE_XFER, TTE_FIN, TTE_WB
	} tte_state_t;

	typedef struct packed {
		logic              req;
		logic              we;
		logic              word;
		logic [23:0]       addr;
		logic [15:0]       wdata;
	} tte_mem_req_t;
endpackage : tte_pkg
`default_nettype wire

// ==== tte_assertions.sv ====
/* Port checker for the transfer engine.
   Bound to tte_engine from the testbench top file. */
`timescale 1ns/10ps
`default_nettype none
module tte_assertions
	import tte_pkg::*;
#(
	parameter logic [23:0] BASE_ADDR = DESC_BASE
) (
	input wire logic         clk_sys_in,
	input wire logic         rst_b_in,
	input wire logic         i2c_channel0_request_in,
	input wire tte_mem_req_t mem_out,
	input wire logic         mem_ack_in,
	input wire logic [15:0]  mem_rdata_in,
	input wire logic         cpu_irq_out,
	input wire logic         busy_out,
	input wire logic [7:0]   transfer_mode_a_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	logic [9:0] busy_cnt;
	sequence s_start;
		$rose(i2c_channel0_request_in) && !busy_out ##1 !busy_out;
	endsequence
	sequence s_fetch;
		mem_out.req && !mem_out.we && mem_out.addr == BASE_ADDR;
	endsequence
	always_ff @(posedge clk_sys_in)
		busy_cnt <= (!rst_b_in || !busy_out) ? 10'h000 : busy_cnt + 10'h001;
	a_start_busy: assert property (
		s_start |=> busy_out) else $error("busy did not follow request");
	a_fetch_base: assert property (
		$rose(busy_out) |=> s_fetch) else $error("first fetch not at base");
	a_desc_bytes: assert property (
		mem_out.req && (mem_out.addr - BASE_ADDR) < 24'h00000C
		|-> !mem_out.word) else $error("descriptor access not bytewise");
	a_req_stable: assert property (
		mem_out.req && !mem_ack_in |=> $stable(mem_out))
		else $error("request changed before ack");
	a_req_drop: assert property (
		mem_out.req && mem_ack_in |=> !mem_out.req)
		else $error("request held after ack");
	a_idle_quiet: assert property (
		!busy_out |-> !mem_out.req) else $error("request while idle");
	a_irq_end: assert property (
		cpu_irq_out |-> ##[0:2] !busy_out) else $error("irq not at end");
	a_irq_pulse: assert property (
		cpu_irq_out |=> !cpu_irq_out) else $error("irq longer than pulse");
	a_busy_bound: assert property (
		busy_cnt < 10'h200) else $error("activation did not end");
endmodule : tte_assertions
`default_nettype wire

// ==== tte_mem_model.sv ====
/* Byte memory on the far side of the engine's memory port.
   Answers each held request with one ack pulse after 0 to 2 waits. */
`timescale 1ns/10ps
`default_nettype none
module tte_mem_model
	import tte_pkg::*;
(
	input  wire logic         clk_sys_in,
	input  wire tte_mem_req_t mem_in,
	output logic              ack_out,
	output logic [15:0]       rdata_out
);
	logic [7:0]  mem [0:65535];
	logic [15:0] a;
	int          seed = 32'hBC25;
	int          wait_n = 0;
	assign a = mem_in.addr[15:0];
	initial ack_out = 1'b0;
	initial rdata_out = 16'h5A5A;
	// Descriptor and data bytes live here, big-endian.
	always @(posedge clk_sys_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (mem_in.req && !ack_out) begin
			if (wait_n == 0) begin
				ack_out <= 1'b1;
				wait_n <= $unsigned($random(seed)) % 3;
				if (mem_in.we) begin
					mem[a] <= mem_in.word ? mem_in.wdata[15:8] : mem_in.wdata[7:0];
					if (mem_in.word)
						mem[a + 16'h1] <= mem_in.wdata[7:0];
				end else
					rdata_out <= mem_in.word ? {mem[a], mem[a + 16'h1]} : {8'h00, mem[a]};
			end else
				wait_n <= wait_n - 1;
		end
	end
endmodule : tte_mem_model
`default_nettype wire

// ==== tb_top.sv ====
/* Self-checking bench for the transfer engine, one unit per descriptor, three in the block mode case.
   Assumes the memory model above on the engine's memory port. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import tte_pkg::*;
	logic         clk_sys_in = 1'b0;
	logic         rst_b_in = 1'b0;
	logic         req = 1'b0;
	tte_mem_req_t mem;
	logic         ack;
	logic [15:0]  rdata;
	logic         cpu_irq_out;
	logic         busy_out;
	logic [7:0]   mode_a;
	int           seed = 32'hBC25;
	int           n_fail = 0;
	int           num_checks = 0;
	int           n_irq = 0;
	int           cyc = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	tte_engine i_tte_engine (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.i2c_channel0_request_in(req), .mem_out(mem), .mem_ack_in(ack),
		.mem_rdata_in(rdata), .cpu_irq_out(cpu_irq_out),
		.busy_out(busy_out), .transfer_mode_a_out(mode_a));
	tte_mem_model i_mem (.clk_sys_in(clk_sys_in), .mem_in(mem),
		.ack_out(ack), .rdata_out(rdata));
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [15:0] dlt(input logic [1:0] m,
			input logic [15:0] st);
		return m[1] ? (m[0] ? -st : st) : 16'h0000;
	endfunction : dlt
	task automatic fire();
		int k;
		n_irq = 0;
		@(posedge clk_sys_in) req <= 1'b1;
		@(posedge clk_sys_in) req <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		k = 0;
		while (busy_out !== 1'b0 && k < 600) begin
			@(posedge clk_sys_in);
			k++;
		end
		chk("busy", 16'h0000, {15'h0000, busy_out});
		repeat (2) @(posedge clk_sys_in);
	endtask : fire
	task automatic run_area(input logic [7:0] ma, mb,
			input logic [15:0] ca, cb, es, ed, eca, ecb, eirq,
			input int nb);
		logic [7:0] b [12];
		logic [7:0] v [4];
		b = '{ma, 8'h00, 8'hE1, 8'h40, mb, 8'h00, 8'hE2, 8'h40, ca[15:8],
			ca[7:0], cb[15:8], cb[7:0]};
		foreach (b[j]) begin
			i_mem.mem[16'hEC00 + j] = b[j];
			i_mem.mem[16'hEC0C + j] = (j == 4) ? {1'b0, mb[6:0]} : b[j];
		end
		foreach (v[j]) begin
			v[j] = 8'($random(seed));
			i_mem.mem[16'hE140 + j] = v[j];
			i_mem.mem[16'hE240 + j] = ~v[j];
		end
		fire();
		foreach (v[j])
			chk("area_unit", {8'h00, ((j < nb) ? v[j] : ~v[j])},
				{8'h00, i_mem.mem[16'hE240 + j]});
		chk("area_src", es,
			{i_mem.mem[16'hEC02], i_mem.mem[16'hEC03]});
		chk("area_dst", ed,
			{i_mem.mem[16'hEC06], i_mem.mem[16'hEC07]});
		chk("area_cnt_a", eca,
			{i_mem.mem[16'hEC08], i_mem.mem[16'hEC09]});
		chk("area_cnt_b", ecb,
			{i_mem.mem[16'hEC0A], i_mem.mem[16'hEC0B]});
		chk("chain_cnt", mb[CHAIN_BIT] ? ca - 16'h0001 : ca,
			{i_mem.mem[16'hEC14], i_mem.mem[16'hEC15]});
		chk("area_irq", eirq, 16'(n_irq));
		$display("area case mode %h done", ma);
	endtask : run_area
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cpu_irq_out === 1'b1)
			n_irq++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic run_case(input logic [3:0] i);
		logic [31:0] r;
		logic [15:0] c, st, d;
		logic [7:0]  ma;
		logic [7:0]  b [12];
		logic        sz, dis;
		r = $random(seed);
		sz = i[0] ^ i[3];
		dis = r[17];
		c = {15'h0000, r[16]} + 16'h0001;
		st = sz ? 16'h0002 : 16'h0001;
		d = r[15:0];
		ma = {i[1:0], i[3:2], MODE_NORMAL, 1'b0, sz};
		b = '{ma, 8'h00, 8'hE1, 8'h40, {1'b0, dis, 6'h00}, 8'h00, 8'hE2,
			8'h40, c[15:8], c[7:0], 8'h00, 8'h00};
		foreach (b[j])
			i_mem.mem[16'hEC00 + j] = b[j];
		i_mem.mem[16'hE140] = d[15:8];
		i_mem.mem[16'hE141] = d[7:0];
		i_mem.mem[16'hE240] = ~d[15:8];
		i_mem.mem[16'hE241] = ~d[7:0];
		fire();
		chk("unit", sz ? d : {d[15:8], ~d[7:0]},
			{i_mem.mem[16'hE240], i_mem.mem[16'hE241]});
		chk("src", 16'hE140 + dlt(i[1:0], st),
			{i_mem.mem[16'hEC02], i_mem.mem[16'hEC03]});
		chk("dst", 16'hE240 + dlt(i[3:2], st),
			{i_mem.mem[16'hEC06], i_mem.mem[16'hEC07]});
		chk("count", c - 16'h0001,
			{i_mem.mem[16'hEC08], i_mem.mem[16'hEC09]});
		chk("irq", (c == 16'h0001 || dis) ? 16'h0001 : 16'h0000,
			16'(n_irq));
		chk("mode_a", {8'h00, ma}, {8'h00, mode_a});
		$display("case %0d done", i);
	endtask : run_case
	initial begin
		repeat (10) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 16; i++)
			run_case(i[3:0]);
		run_area(8'hA8, 8'h00, 16'h0300, 16'h0002, 16'hE143,
			16'hE240, 16'h0300, 16'h0001, 16'h0000, 3);
		run_area(8'hA6, 8'h40, 16'h0101, 16'h0000, 16'hE140,
			16'hE241, 16'h0101, 16'h0000, 16'h0001, 1);
		run_area(8'hA0, 8'h80, 16'h0002, 16'h0000, 16'hE141,
			16'hE241, 16'h0001, 16'h0000, 16'h0000, 1);
		conclude();
	end
endmodule : tb_top
bind tte_engine tte_assertions #(.BASE_ADDR(BASE_ADDR)) i_chk (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
	.i2c_channel0_request_in(i2c_channel0_request_in), .mem_out(mem_out),
	.mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
	.cpu_irq_out(cpu_irq_out), .busy_out(busy_out),
	.transfer_mode_a_out(transfer_mode_a_out));
`default_nettype wire
